// ---- include/dsocr_pkg.sv ----
//------------------------------------------------------------
// Contract
//------------------------------------------------------------
// Contract
// - bridge2 reported as eight-bit fault code
// - stage27 bits 5-4: scg, ol, scb, ok
// - high-side stage26/25: scb 00, scg 10
// - ignition register holds coil4..coil1 two-bit codes
// - supply bit 7 follows key hysteresis
// - supply bit 6 shows relay overcurrent off
// - flywheel fault only in fully adaptive mode
// - tracker codes, overload beats overvoltage
// - reset register cause and fault flags
// - summary bits for stage groups a, b
// - lockout keeps stages off, ignores command data
// - lockout unchanged by reads, set by resets
// - overtemperature flags bits 7 to 4
// - long dip reset latched even when masked
// - link error flags bits 2 to 0
// - io rail undervolt over 225 ms flags
// - safe-off flags after 225 and 600 ms
// - safe-off only without power latch; key or watchdog
// - register zero read by 7, cleared by 5
// - data frame bit0 zero, data above, 1=on
// - diagnostic bits clear when their register read; register zero clears only on command 5
package dsocr_pkg;
	// register addresses
	localparam logic [3:0] ADDR_SAFE_OFF = 4'h0;
	localparam logic [3:0] ADDR_SUPPLY = 4'h3;
	localparam logic [3:0] ADDR_RESET = 4'h7;
	localparam logic [3:0] ADDR_BRIDGE2 = 4'ha;
	localparam logic [3:0] ADDR_OVT = 4'hb;
	localparam logic [3:0] ADDR_IGN = 4'he;
	// read command numbers
	localparam logic [2:0] CMD_RD_REG0 = 3'h7;
	localparam logic [2:0] CMD_CLR_REG0 = 3'h5;
	// two-bit codes, low-side, high-side and tracker
	localparam logic [1:0] LS_SCG = 2'h0;
	localparam logic [1:0] LS_OL = 2'h1;
	localparam logic [1:0] LS_SCB = 2'h2;
	localparam logic [1:0] CODE_OK = 2'h3;
	localparam logic [1:0] HS_SCB = 2'h0;
	localparam logic [1:0] HS_SCG = 2'h2;
	localparam logic [1:0] TRK_OVL = 2'h1;
	localparam logic [1:0] TRK_OVOT = 2'h2;
	// bridge codes
	localparam logic [7:0] BR_SCG_OFF = 8'h01;
	localparam logic [7:0] BR_SCB_OFF = 8'h05;
	localparam logic [7:0] BR_OL_OFF = 8'h04;
	localparam logic [7:0] BR_OL_ON = 8'h02;
	localparam logic [7:0] BR_OC_ON = 8'h03;
	localparam logic [7:0] BR_RUN_ON = 8'h07;
	localparam logic [7:0] BR_OK = 8'hff;
	// field positions
	localparam int B_IOUV = 7;
	localparam int B_WD_LATCH = 6;
	localparam int B_SEO_A = 5;
	localparam int B_SEO_B = 4;
	localparam int B_WD_PIN = 3;
	localparam int B_KEY_FLT = 0;
	localparam int B_KEY = 7;
	localparam int B_RELAY_OC = 6;
	localparam int B_FW_ACT = 5;
	localparam int B_FW_FLT = 4;
	localparam int B_LOCKOUT = 1;
	// reset values
	localparam logic [7:0] CMD1_RST = 8'h00;
	// timing
	localparam int CLK_KHZ = 40000;
	localparam int T_IO_UV_MS = 225;
	localparam int T_SEO_A_MS = 225;
	localparam int T_SEO_B_MS = 600;
	localparam int IO_UV_CYC = T_IO_UV_MS * CLK_KHZ;
	localparam int SEO_A_CYC = T_SEO_A_MS * CLK_KHZ;
	localparam int SEO_B_CYC = T_SEO_B_MS * CLK_KHZ;
	localparam int CNT_W = 25;
	localparam int PIN_W = 4;

	function automatic logic [1:0] fn_code_ls(input logic scg, input logic ol, input logic scb);
		fn_code_ls = scg ? LS_SCG : (scb ? LS_SCB : (ol ? LS_OL : CODE_OK));
	endfunction

	function automatic logic [1:0] fn_code_hs(input logic scg, input logic ol, input logic scb);
		fn_code_hs = scb ? HS_SCB : (scg ? HS_SCG : (ol ? LS_OL : CODE_OK));
	endfunction

	// sticky two-bit code: a fresh fault overwrites, clear returns to ok
	function automatic logic [1:0] fn_hold2(input logic [1:0] cur, input logic clr, input logic [1:0] now);
		fn_hold2 = (now != CODE_OK) ? now : (clr ? CODE_OK : cur);
	endfunction
endpackage

// ---- core/dsocr_sync.sv ----
`timescale 1ns/1ps
module dsocr_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins in, filtered levels out
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] init_val,
	output logic [W-1:0] lvl_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] lvl_r;
	logic [W-1:0] lvl_nxt;

	// a level counts only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
		end
	end

	// init_val is a tie-off constant from the parent; every stage starts at the
	// idle level, so the release of reset shows no false edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_r <= init_val;
			s2_r <= init_val;
			s3_r <= init_val;
			lvl_r <= init_val;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign lvl_out = lvl_r;
endmodule

// ---- core/dsocr_top.sv ----
`timescale 1ns/1ps
module dsocr_top
	import dsocr_pkg::*;
#(
	parameter int IO_UV_CYCLES = dsocr_pkg::IO_UV_CYC,
	parameter int SEO_A_CYCLES = dsocr_pkg::SEO_A_CYC,
	parameter int SEO_B_CYCLES = dsocr_pkg::SEO_B_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins
	input wire logic reset_pin_n,
	input wire logic watchdog_output_pin,
	input wire logic key_above_high,
	input wire logic key_below_low,
	// serial read commands
	input wire logic rd_req,
	input wire logic [2:0] rd_cmd,
	input wire logic [3:0] rd_addr,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// data frames and control commands
	input wire logic frame_valid,
	input wire logic [8:0] frame_data,
	input wire logic start_cmd,
	input wire logic soft_reset_cmd,
	// configuration levels
	input wire logic cps_bridge_mode,
	input wire logic fully_adaptive,
	input wire logic power_latch_cfg,
	input wire logic key_filtered,
	// status levels
	input wire logic relay_overcurrent_off,
	input wire logic flywheel_diag_active,
	input wire logic io_rail_undervolt,
	// stage 25..28, stage 21..24 and bridge2 fault detectors
	input wire logic [3:0] cps_scg,
	input wire logic [3:0] cps_ol,
	input wire logic [3:0] cps_scb,
	input wire logic br_scg_off,
	input wire logic br_scb_off,
	input wire logic br_ol_off,
	input wire logic br_ol_on,
	input wire logic br_oc_on,
	input wire logic br_running,
	input wire logic stages21_24_fault,
	// ignition and group a fault detectors
	input wire logic [3:0] ign_scg,
	input wire logic [3:0] ign_ol,
	input wire logic [3:0] ign_scb,
	input wire logic stages_a_fault,
	// supply events
	input wire logic flywheel_fault,
	input wire logic [1:0] trk_overload,
	input wire logic [1:0] trk_ovot,
	input wire logic alt_reset_evt,
	input wire logic short_dip_evt,
	input wire logic long_dip_evt,
	input wire logic rail5_ov_evt,
	input wire logic rail33_uv_evt,
	input wire logic batt_ov_evt,
	input wire logic watchdog_reset_evt,
	// overtemperature and link events
	input wire logic ot_trk_evt,
	input wire logic ot_stage_evt,
	input wire logic ot_relay_evt,
	input wire logic ot_rail33_evt,
	input wire logic [3:0] can_err_evt,
	input wire logic frame_len_evt,
	input wire logic frame_timeout_evt,
	// stage switches
	output logic stage1_switch,
	output logic stage2_switch,
	output logic stage3_switch,
	output logic stage4_switch,
	output logic stage5_switch,
	output logic stage20_switch,
	output logic stage8_switch,
	output logic stage19_switch,
	output logic stage_lockout
);
	import dsocr_pkg::*;

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	logic [PIN_W-1:0] pin_lvl;
	logic pin_rst_n;
	logic wd_pin;
	logic key_hi;
	logic key_lo;

	dsocr_sync #(
		.W(PIN_W)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in({reset_pin_n, watchdog_output_pin, key_above_high, key_below_low}),
		.init_val(4'h8),
		.lvl_out(pin_lvl)
	);

	assign pin_rst_n = pin_lvl[3];
	assign wd_pin = pin_lvl[2];
	assign key_hi = pin_lvl[1];
	assign key_lo = pin_lvl[0];

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic [7:0] cmd1_r, cmd1_nxt;
	logic [7:0] sw_r, sw_nxt;
	logic lock_r, lock_nxt;
	logic [7:0] ign_r, ign_nxt;
	logic [7:0] cps_r, cps_nxt;
	logic key_r, key_nxt;
	logic fw_r, fw_nxt;
	logic [3:0] trk_r, trk_nxt;
	logic [7:0] rst_reg_r, rst_reg_nxt;
	logic [7:0] ovt_r, ovt_nxt;
	logic iouv_r, iouv_nxt;
	logic wdl_r, wdl_nxt;
	logic seo_a_r, seo_a_nxt;
	logic seo_b_r, seo_b_nxt;
	logic [CNT_W-1:0] iouv_cnt_r, iouv_cnt_nxt;
	logic [CNT_W-1:0] seo_cnt_r, seo_cnt_nxt;
	logic seo_wd_r, seo_wd_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;

	//------------------------------------------------------------
	// read decode and live codes
	//------------------------------------------------------------
	logic rd_reg0, clr_reg0, clr_supply, clr_rst, clr_ovt, clr_ign, clr_cps;
	logic [7:0] ign_now, cps_now, reg0_view, supply_view;
	logic grp_a_evt, grp_b_evt, seo_trig;

	always_comb begin
		rd_reg0 = rd_req && (rd_cmd == CMD_RD_REG0 || rd_cmd == CMD_CLR_REG0);
		clr_reg0 = rd_req && rd_cmd == CMD_CLR_REG0;
		clr_supply = rd_req && !rd_reg0 && rd_addr == ADDR_SUPPLY;
		clr_rst = rd_req && !rd_reg0 && rd_addr == ADDR_RESET;
		clr_ovt = rd_req && !rd_reg0 && rd_addr == ADDR_OVT;
		clr_ign = rd_req && !rd_reg0 && rd_addr == ADDR_IGN;
		clr_cps = rd_req && !rd_reg0 && rd_addr == ADDR_BRIDGE2;
		for (int i = 0; i < 4; i++) begin
			ign_now[2*i +: 2] = fn_code_ls(ign_scg[i], ign_ol[i], ign_scb[i]);
		end
		// index 0..3 is stage25..28; 25 and 26 are high-side drivers
		cps_now[1:0] = fn_code_hs(cps_scg[0], cps_ol[0], cps_scb[0]);
		cps_now[3:2] = fn_code_hs(cps_scg[1], cps_ol[1], cps_scb[1]);
		cps_now[5:4] = fn_code_ls(cps_scg[2], cps_ol[2], cps_scb[2]);
		cps_now[7:6] = fn_code_ls(cps_scg[3], cps_ol[3], cps_scb[3]);
		if (cps_bridge_mode) begin
			// shorts first, then overcurrent, then open load, then busy
			if (br_scg_off) begin
				cps_now = BR_SCG_OFF;
			end else if (br_scb_off) begin
				cps_now = BR_SCB_OFF;
			end else if (br_oc_on) begin
				cps_now = BR_OC_ON;
			end else if (br_ol_off) begin
				cps_now = BR_OL_OFF;
			end else if (br_ol_on) begin
				cps_now = BR_OL_ON;
			end else if (br_running) begin
				cps_now = BR_RUN_ON;
			end else begin
				cps_now = BR_OK;
			end
		end
		grp_a_evt = stages_a_fault || (ign_now != 8'hff);
		grp_b_evt = stages21_24_fault || (cps_now != 8'hff);
		// safe-off only runs with the power latch disabled
		seo_trig = !power_latch_cfg && (!key_filtered || seo_wd_r);
		reg0_view = 8'h00;
		reg0_view[B_IOUV] = iouv_r;
		reg0_view[B_WD_LATCH] = wdl_r;
		reg0_view[B_SEO_A] = seo_a_r;
		reg0_view[B_SEO_B] = seo_b_r;
		reg0_view[B_WD_PIN] = wd_pin;
		reg0_view[B_KEY_FLT] = key_filtered;
		supply_view = {key_r, relay_overcurrent_off, flywheel_diag_active, fw_r, trk_r};
	end

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		// lockout: power-on, soft reset and the reset pin all force it
		lock_nxt = lock_r;
		if (start_cmd) begin
			lock_nxt = 1'b0;
		end
		if (soft_reset_cmd || !pin_rst_n) begin
			lock_nxt = 1'b1;
		end
		cmd1_nxt = cmd1_r;
		if (frame_valid && !frame_data[0] && !lock_r) begin
			cmd1_nxt = frame_data[8:1];
		end
		if (soft_reset_cmd || !pin_rst_n) begin
			cmd1_nxt = CMD1_RST;
		end
		sw_nxt = lock_nxt ? 8'h00 : cmd1_nxt;

		for (int i = 0; i < 4; i++) begin
			ign_nxt[2*i +: 2] = fn_hold2(ign_r[2*i +: 2], clr_ign, ign_now[2*i +: 2]);
		end
		// bridge codes ride in the same byte; a fresh fault code wins
		if (cps_bridge_mode) begin
			cps_nxt = (cps_now != BR_OK) ? cps_now : (clr_cps ? BR_OK : cps_r);
		end else begin
			for (int i = 0; i < 4; i++) begin
				cps_nxt[2*i +: 2] = fn_hold2(cps_r[2*i +: 2], clr_cps, cps_now[2*i +: 2]);
			end
		end

		key_nxt = key_hi ? 1'b1 : (key_lo ? 1'b0 : key_r);
		fw_nxt = fully_adaptive && (flywheel_fault || (fw_r && !clr_supply));
		for (int i = 0; i < 2; i++) begin
			trk_nxt[2*i +: 2] = fn_hold2(trk_r[2*i +: 2], clr_supply,
				trk_overload[i] ? TRK_OVL : (trk_ovot[i] ? TRK_OVOT : CODE_OK));
		end

		rst_reg_nxt = clr_rst ? 8'h00 : rst_reg_r;
		rst_reg_nxt |= {alt_reset_evt, grp_a_evt, short_dip_evt, grp_b_evt,
			rail5_ov_evt, rail33_uv_evt, 1'b0, batt_ov_evt};
		rst_reg_nxt[B_LOCKOUT] = lock_nxt;

		// long dip is latched regardless of any undervoltage mask
		ovt_nxt = clr_ovt ? 8'h00 : ovt_r;
		ovt_nxt |= {ot_trk_evt, ot_stage_evt, ot_relay_evt, ot_rail33_evt,
			long_dip_evt, |can_err_evt, frame_len_evt, frame_timeout_evt};

		iouv_cnt_nxt = '0;
		if (io_rail_undervolt) begin
			iouv_cnt_nxt = (iouv_cnt_r == CNT_W'(IO_UV_CYCLES)) ? iouv_cnt_r : iouv_cnt_r + 1'b1;
		end
		iouv_nxt = (iouv_r && !clr_reg0) || (iouv_cnt_nxt == CNT_W'(IO_UV_CYCLES));
		wdl_nxt = (wdl_r && !clr_reg0) || watchdog_reset_evt;

		seo_wd_nxt = !power_latch_cfg && (seo_wd_r || watchdog_reset_evt);
		seo_cnt_nxt = '0;
		if (seo_trig) begin
			seo_cnt_nxt = (seo_cnt_r == CNT_W'(SEO_B_CYCLES)) ? seo_cnt_r : seo_cnt_r + 1'b1;
		end
		seo_a_nxt = (seo_a_r && !clr_reg0) || (seo_trig && seo_cnt_nxt == CNT_W'(SEO_A_CYCLES));
		seo_b_nxt = (seo_b_r && !clr_reg0) || (seo_trig && seo_cnt_nxt == CNT_W'(SEO_B_CYCLES));

		rd_valid_nxt = rd_req;
		rd_data_nxt = 8'h00;
		if (rd_req) begin
			if (rd_reg0) begin
				rd_data_nxt = reg0_view;
			end else begin
				case (rd_addr)
					ADDR_SAFE_OFF: rd_data_nxt = reg0_view;
					ADDR_SUPPLY: rd_data_nxt = supply_view;
					ADDR_RESET: rd_data_nxt = rst_reg_r;
					ADDR_OVT: rd_data_nxt = ovt_r;
					ADDR_IGN: rd_data_nxt = ign_r;
					ADDR_BRIDGE2: rd_data_nxt = cps_r;
					default: rd_data_nxt = 8'h00;
				endcase
			end
		end
	end

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd1_r <= CMD1_RST;
			sw_r <= 8'h00;
			lock_r <= 1'b1;
			ign_r <= 8'hff;
			cps_r <= 8'hff;
			key_r <= 1'b0;
			fw_r <= 1'b0;
			trk_r <= 4'hf;
			rst_reg_r <= 8'h02;
			ovt_r <= 8'h00;
			iouv_r <= 1'b0;
			wdl_r <= 1'b0;
			seo_a_r <= 1'b0;
			seo_b_r <= 1'b0;
			iouv_cnt_r <= '0;
			seo_cnt_r <= '0;
			seo_wd_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= 8'h00;
		end else begin
			cmd1_r <= cmd1_nxt;
			sw_r <= sw_nxt;
			lock_r <= lock_nxt;
			ign_r <= ign_nxt;
			cps_r <= cps_nxt;
			key_r <= key_nxt;
			fw_r <= fw_nxt;
			trk_r <= trk_nxt;
			rst_reg_r <= rst_reg_nxt;
			ovt_r <= ovt_nxt;
			iouv_r <= iouv_nxt;
			wdl_r <= wdl_nxt;
			seo_a_r <= seo_a_nxt;
			seo_b_r <= seo_b_nxt;
			iouv_cnt_r <= iouv_cnt_nxt;
			seo_cnt_r <= seo_cnt_nxt;
			seo_wd_r <= seo_wd_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// command bits 7..0 drive stages 1,2,3,4,5,20,8,19
	assign {stage1_switch, stage2_switch, stage3_switch, stage4_switch,
		stage5_switch, stage20_switch, stage8_switch, stage19_switch} = sw_r;
	assign stage_lockout = lock_r;
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_frame_ok;
		frame_valid && !frame_data[0] && !lock_r && !soft_reset_cmd && pin_rst_n;
	endsequence

	sequence s_ot_read_quiet;
		clr_ovt && !(ot_trk_evt || ot_stage_evt || ot_relay_evt || ot_rail33_evt);
	endsequence

	a_lockout_gates: assert property (lock_r |-> sw_r == 8'h00)
		else $error("stage on while locked out");
	a_locked_frame_dropped: assert property (lock_r && frame_valid |=> cmd1_r == $past(cmd1_r))
		else $error("frame accepted while locked out");
	a_frame_written: assert property (s_frame_ok |=> cmd1_r == $past(frame_data[8:1]))
		else $error("data frame not stored");
	a_lockout_read: assert property (rd_req && !start_cmd && !soft_reset_cmd && pin_rst_n |=> $stable(lock_r))
		else $error("read changed lockout");
	a_soft_reset_lock: assert property (soft_reset_cmd |=> lock_r ##1 (lock_r || $past(start_cmd)))
		else $error("soft reset did not lock stages");
	a_fw_limited: assert property (rd_req && rd_addr == ADDR_SUPPLY && !fully_adaptive |=> rd_data[B_FW_FLT] == 1'b0)
		else $error("flywheel fault shown in limited mode");
	a_trk_priority: assert property (trk_overload[0] && trk_ovot[0] |=> trk_r[1:0] == TRK_OVL)
		else $error("tracker priority wrong");
	a_ot_clear_read: assert property (s_ot_read_quiet |=> ovt_r[7:4] == 4'h0)
		else $error("overtemperature not cleared by read");
	a_ot_set_wins: assert property (ot_stage_evt && clr_ovt |=> ovt_r[6] ##1 (ovt_r[6] || $past(clr_ovt)))
		else $error("overtemperature event lost");
	a_reg0_keep_cmd7: assert property (rd_req && rd_cmd == CMD_RD_REG0 && seo_a_r |=> seo_a_r)
		else $error("read command 7 cleared register zero");
	a_iouv_flag: assert property (io_rail_undervolt && iouv_cnt_r == CNT_W'(IO_UV_CYCLES - 1) |=> iouv_r)
		else $error("io undervolt flag late");
	a_wd_latch: assert property (watchdog_reset_evt |=> wdl_r [*2] or (wdl_r ##1 $past(clr_reg0)))
		else $error("watchdog reset not latched");
endmodule

// ---- verification/dsocr_mcu_model.sv ----
`timescale 1ns/1ps
module dsocr_mcu_model (
	// clock
	input wire logic core_clk,
	// read answer
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	// requests
	output logic rd_req,
	output logic [2:0] rd_cmd,
	output logic [3:0] rd_addr,
	output logic frame_valid,
	output logic [8:0] frame_data,
	output logic start_cmd,
	output logic soft_reset_cmd
);
	// ------------------------------------------------
	// controller side: every request is a one-cycle pulse
	// ------------------------------------------------
	initial begin
		rd_req = 1'b0;
		rd_cmd = 3'h0;
		rd_addr = 4'h0;
		frame_valid = 1'b0;
		frame_data = 9'h155;
		start_cmd = 1'b0;
		soft_reset_cmd = 1'b0;
	end

	task automatic read(input logic [2:0] cmd, input logic [3:0] addr, output logic [7:0] data, output bit ok);
		ok = 1'b0;
		data = 8'h00;
		@(negedge core_clk);
		rd_req = 1'b1;
		rd_cmd = cmd;
		rd_addr = addr;
		@(negedge core_clk);
		rd_req = 1'b0;
		// released select lines must not look like the last request
		rd_cmd = ~cmd;
		rd_addr = ~addr;
		for (int n = 0; n < 4 && !ok; n++) begin
			if (rd_valid === 1'b1) begin
				data = rd_data;
				ok = 1'b1;
			end else begin
				@(negedge core_clk);
			end
		end
	endtask

	// selection bit travels in bit 0, the command byte above it
	task automatic send_frame(input logic [8:0] d);
		@(negedge core_clk);
		frame_valid = 1'b1;
		frame_data = d;
		@(negedge core_clk);
		frame_valid = 1'b0;
		frame_data = ~d;
	endtask

	// outputs are only expected to follow commands after this
	task automatic start_stages();
		@(negedge core_clk);
		start_cmd = 1'b1;
		@(negedge core_clk);
		start_cmd = 1'b0;
	endtask

	task automatic soft_reset();
		@(negedge core_clk);
		soft_reset_cmd = 1'b1;
		@(negedge core_clk);
		soft_reset_cmd = 1'b0;
	endtask
endmodule

// ---- verification/dsocr_tb_top.sv ----
`timescale 1ns/1ps
module dsocr_tb_top;
	import dsocr_pkg::*;
	logic core_clk, rst, reset_pin_n, watchdog_output_pin, key_above_high, key_below_low;
	logic rd_req, rd_valid, frame_valid, start_cmd, soft_reset_cmd, stage_lockout;
	logic [2:0] rd_cmd;
	logic [3:0] rd_addr;
	logic [7:0] rd_data, sw;
	logic [8:0] frame_data;
	logic cps_bridge_mode, fully_adaptive, power_latch_cfg, key_filtered;
	logic relay_overcurrent_off, flywheel_diag_active, io_rail_undervolt, flywheel_fault;
	logic [3:0] cps_scg, cps_ol, cps_scb, ign_scg, ign_ol, ign_scb, can_err_evt, ot_evt;
	logic [5:0] br_in;
	logic [4:0] rst_evt;
	logic [1:0] trk_overload, trk_ovot;
	logic stages21_24_fault, stages_a_fault, long_dip_evt, watchdog_reset_evt, frame_len_evt, frame_timeout_evt;
	int n_fail, checks;

	// short counts keep the timed flags inside a brief run
	dsocr_top #(.IO_UV_CYCLES(20), .SEO_A_CYCLES(20), .SEO_B_CYCLES(50)) dut_u (
		.core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
		.watchdog_output_pin(watchdog_output_pin), .key_above_high(key_above_high),
		.key_below_low(key_below_low), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data), .frame_valid(frame_valid), .frame_data(frame_data),
		.start_cmd(start_cmd), .soft_reset_cmd(soft_reset_cmd), .cps_bridge_mode(cps_bridge_mode),
		.fully_adaptive(fully_adaptive), .power_latch_cfg(power_latch_cfg), .key_filtered(key_filtered),
		.relay_overcurrent_off(relay_overcurrent_off), .flywheel_diag_active(flywheel_diag_active),
		.io_rail_undervolt(io_rail_undervolt), .cps_scg(cps_scg), .cps_ol(cps_ol), .cps_scb(cps_scb),
		.br_scg_off(br_in[5]), .br_scb_off(br_in[4]), .br_ol_off(br_in[3]), .br_ol_on(br_in[2]),
		.br_oc_on(br_in[1]), .br_running(br_in[0]), .stages21_24_fault(stages21_24_fault),
		.ign_scg(ign_scg), .ign_ol(ign_ol), .ign_scb(ign_scb), .stages_a_fault(stages_a_fault),
		.flywheel_fault(flywheel_fault), .trk_overload(trk_overload), .trk_ovot(trk_ovot),
		.alt_reset_evt(rst_evt[4]), .short_dip_evt(rst_evt[3]), .long_dip_evt(long_dip_evt),
		.rail5_ov_evt(rst_evt[2]), .rail33_uv_evt(rst_evt[1]), .batt_ov_evt(rst_evt[0]),
		.watchdog_reset_evt(watchdog_reset_evt), .ot_trk_evt(ot_evt[3]), .ot_stage_evt(ot_evt[2]),
		.ot_relay_evt(ot_evt[1]), .ot_rail33_evt(ot_evt[0]), .can_err_evt(can_err_evt),
		.frame_len_evt(frame_len_evt), .frame_timeout_evt(frame_timeout_evt),
		.stage1_switch(sw[7]), .stage2_switch(sw[6]), .stage3_switch(sw[5]), .stage4_switch(sw[4]),
		.stage5_switch(sw[3]), .stage20_switch(sw[2]), .stage8_switch(sw[1]), .stage19_switch(sw[0]),
		.stage_lockout(stage_lockout)
	);

	dsocr_mcu_model mcu_u (
		.core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_req(rd_req), .rd_cmd(rd_cmd),
		.rd_addr(rd_addr), .frame_valid(frame_valid), .frame_data(frame_data), .start_cmd(start_cmd),
		.soft_reset_cmd(soft_reset_cmd)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic end_sim();
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd(input logic [2:0] cmd, input logic [3:0] addr, input logic [7:0] exp, input string name);
		logic [7:0] d;
		bit ok;
		mcu_u.read(cmd, addr, d, ok);
		if (!ok) begin
			n_fail++;
			$display("ERROR %s expected valid seen none", name);
			end_sim();
		end
		chk(name, exp, d);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_reset();
		chk("lockout", 8'h01, {7'h00, stage_lockout});
		chk("switches", CMD1_RST, sw);
		rd(3'h0, ADDR_RESET, 8'h02, "reset_reg");
		rd(3'h0, 4'h1, 8'h00, "unmapped");
	endtask

	task automatic t_frames();
		mcu_u.send_frame(9'h1fe);
		cyc(2);
		chk("locked_sw", 8'h00, sw);
		rd(3'h0, ADDR_RESET, 8'h02, "lock_read");
		mcu_u.start_stages();
		cyc(2);
		chk("unlock", 8'h00, {7'h00, stage_lockout});
		mcu_u.send_frame(9'h1fe);
		cyc(2);
		chk("all_on", 8'hff, sw);
		mcu_u.send_frame(9'h001);
		cyc(2);
		chk("bad_select", 8'hff, sw);
		mcu_u.send_frame(9'h0aa);
		cyc(2);
		chk("stage_order", 8'h55, sw);
		mcu_u.soft_reset();
		cyc(2);
		chk("soft_sw", 8'h00, sw);
		chk("soft_lock", 8'h01, {7'h00, stage_lockout});
		mcu_u.start_stages();
		mcu_u.send_frame(9'h1fe);
		cyc(2);
		reset_pin_n = 1'b0;
		cyc(6);
		reset_pin_n = 1'b1;
		cyc(6);
		chk("pin_sw", 8'h00, sw);
		chk("pin_lock", 8'h01, {7'h00, stage_lockout});
	endtask

	task automatic t_codes();
		logic [7:0] br_exp [6];
		br_exp = '{BR_SCG_OFF, BR_SCB_OFF, BR_OL_OFF, BR_OL_ON, BR_OC_ON, BR_RUN_ON};
		ign_scg = 4'h8;
		ign_ol = 4'h4;
		ign_scb = 4'h2;
		cyc(1);
		ign_scg = 4'h0;
		ign_ol = 4'h0;
		ign_scb = 4'h0;
		rd(3'h0, ADDR_IGN, 8'h1b, "ign_codes");
		rd(3'h0, ADDR_IGN, 8'hff, "ign_clr");
		rd(3'h0, ADDR_RESET, 8'h42, "group_a");
		rd(3'h0, ADDR_RESET, 8'h02, "group_a_clr");
		cps_bridge_mode = 1'b0;
		cps_scg = 4'h5;
		cps_scb = 4'h2;
		cyc(1);
		cps_scg = 4'h0;
		cps_scb = 4'h0;
		rd(3'h0, ADDR_BRIDGE2, 8'hc2, "single_a");
		cps_ol = 4'h4;
		cps_scg = 4'h2;
		cps_scb = 4'h1;
		cyc(1);
		cps_ol = 4'h0;
		cps_scg = 4'h0;
		cps_scb = 4'h0;
		rd(3'h0, ADDR_BRIDGE2, 8'hd8, "single_b");
		rd(3'h0, ADDR_RESET, 8'h12, "group_b");
		stages_a_fault = 1'b1;
		stages21_24_fault = 1'b1;
		cps_ol = 4'h8;
		ign_scb = 4'h1;
		cyc(1);
		stages_a_fault = 1'b0;
		stages21_24_fault = 1'b0;
		cps_ol = 4'h0;
		ign_scb = 4'h0;
		rd(3'h0, ADDR_BRIDGE2, 8'h7f, "stage28_ol");
		rd(3'h0, ADDR_IGN, 8'hfe, "coil1_scb");
		rd(3'h0, ADDR_RESET, 8'h52, "groups_direct");
		cps_bridge_mode = 1'b1;
		for (int i = 0; i < 6; i++) begin
			br_in = 6'(6'h20 >> i);
			cyc(1);
			br_in = 6'h00;
			rd(3'h0, ADDR_BRIDGE2, br_exp[i], "bridge");
		end
		rd(3'h0, ADDR_BRIDGE2, BR_OK, "bridge_clr");
		rd(3'h0, ADDR_RESET, 8'h12, "group_b_br");
	endtask

	task automatic t_supply();
		key_above_high = 1'b1;
		relay_overcurrent_off = 1'b1;
		flywheel_diag_active = 1'b1;
		fully_adaptive = 1'b1;
		flywheel_fault = 1'b1;
		trk_overload = 2'b01;
		trk_ovot = 2'b11;
		cyc(1);
		flywheel_fault = 1'b0;
		trk_overload = 2'b00;
		trk_ovot = 2'b00;
		cyc(5);
		key_above_high = 1'b0;
		rd(3'h0, ADDR_SUPPLY, 8'hf9, "supply_set");
		fully_adaptive = 1'b0;
		flywheel_fault = 1'b1;
		key_below_low = 1'b1;
		cyc(1);
		flywheel_fault = 1'b0;
		cyc(5);
		key_below_low = 1'b0;
		rd(3'h0, ADDR_SUPPLY, 8'h6f, "supply_limited");
		relay_overcurrent_off = 1'b0;
		flywheel_diag_active = 1'b0;
		rd(3'h0, ADDR_SUPPLY, 8'h0f, "supply_idle");
	endtask

	task automatic t_events();
		rst_evt = 5'h1f;
		cyc(1);
		rst_evt = 5'h00;
		rd(3'h0, ADDR_RESET, 8'haf, "reset_flags");
		rd(3'h0, ADDR_RESET, 8'h02, "reset_clr");
		ot_evt = 4'hf;
		long_dip_evt = 1'b1;
		frame_len_evt = 1'b1;
		frame_timeout_evt = 1'b1;
		cyc(1);
		ot_evt = 4'h0;
		long_dip_evt = 1'b0;
		frame_len_evt = 1'b0;
		frame_timeout_evt = 1'b0;
		rd(3'h0, ADDR_OVT, 8'hfb, "ovt_flags");
		rd(3'h0, ADDR_OVT, 8'h00, "ovt_clr");
		for (int i = 0; i < 4; i++) begin
			can_err_evt = 4'(1 << i);
			cyc(1);
			can_err_evt = 4'h0;
			rd(3'h0, ADDR_OVT, 8'h04, "bus_err");
		end
		// event held across the clearing read: the set must win
		ot_evt = 4'h4;
		rd(3'h0, ADDR_OVT, 8'h40, "ovt_pre");
		ot_evt = 4'h0;
		rd(3'h0, ADDR_OVT, 8'h40, "ovt_set_wins");
	endtask

	task automatic t_reg0();
		io_rail_undervolt = 1'b1;
		cyc(10);
		io_rail_undervolt = 1'b0;
		rd(CMD_RD_REG0, 4'h0, 8'h01, "io_short");
		io_rail_undervolt = 1'b1;
		watchdog_output_pin = 1'b1;
		watchdog_reset_evt = 1'b1;
		power_latch_cfg = 1'b0;
		key_filtered = 1'b0;
		cyc(1);
		watchdog_reset_evt = 1'b0;
		cyc(60);
		rd(CMD_RD_REG0, ADDR_IGN, 8'hf8, "reg0");
		rd(CMD_RD_REG0, 4'h0, 8'hf8, "reg0_kept");
		io_rail_undervolt = 1'b0;
		watchdog_output_pin = 1'b0;
		power_latch_cfg = 1'b1;
		cyc(6);
		rd(CMD_CLR_REG0, ADDR_OVT, 8'hf0, "reg0_clr");
		rd(CMD_RD_REG0, 4'h0, 8'h00, "reg0_empty");
		key_filtered = 1'b1;
		power_latch_cfg = 1'b0;
		watchdog_reset_evt = 1'b1;
		cyc(1);
		watchdog_reset_evt = 1'b0;
		cyc(60);
		power_latch_cfg = 1'b1;
		rd(CMD_CLR_REG0, 4'h0, 8'h71, "seo_watchdog");
		rd(CMD_RD_REG0, 4'h0, 8'h01, "seo_clr");
	endtask

	initial begin
		n_fail = 0;
		checks = 0;
		rst = 1'b1;
		reset_pin_n = 1'b1;
		{watchdog_output_pin, key_above_high, key_below_low} = 3'h0;
		{cps_bridge_mode, fully_adaptive, power_latch_cfg, key_filtered} = 4'h3;
		{relay_overcurrent_off, flywheel_diag_active, io_rail_undervolt, flywheel_fault} = 4'h0;
		{cps_scg, cps_ol, cps_scb, ign_scg, ign_ol, ign_scb, can_err_evt, ot_evt} = 32'h0;
		{br_in, rst_evt, trk_overload, trk_ovot} = 15'h0;
		{stages21_24_fault, stages_a_fault, long_dip_evt, watchdog_reset_evt} = 4'h0;
		{frame_len_evt, frame_timeout_evt} = 2'h0;
		cyc(12);
		rst = 1'b0;
		cyc(1);
		t_reset();
		t_frames();
		t_codes();
		t_supply();
		t_events();
		t_reg0();
		end_sim();
	end
endmodule
